/* logic/qmm_params.svh */
`ifndef QMM_PARAMS_SVH
`define QMM_PARAMS_SVH
`define QMM_CH_W 5
`define QMM_CH_INIT 5'h00
`define QMM_CH_ALL_DONE 5'h01
`define QMM_CH_ISSUED_SZ 5'h02
`define QMM_CH_PEND_SZ 5'h03
`define QMM_CH_RSP_SZ 5'h04
`define QMM_CH_PUSH 5'h05
`define QMM_CH_POP 5'h06
`define QMM_CH_SET_DATA 5'h07
`define QMM_CH_SET_ADDR 5'h08
`define QMM_CH_SET_BE 5'h09
`define QMM_CH_SET_BCNT 5'h0A
`define QMM_CH_SET_IDLE 5'h0B
`define QMM_CH_SET_REQ 5'h0C
`define QMM_CH_SET_INDEX 5'h0D
`define QMM_CH_GET_REQ 5'h0E
`define QMM_CH_GET_DATA 5'h0F
`define QMM_CH_GET_ADDR 5'h10
`define QMM_CH_GET_BE 5'h11
`define QMM_CH_GET_BSIZE 5'h12
`define QMM_CH_GET_LAT 5'h13
`define QMM_CH_GET_WAIT 5'h14
`define QMM_CH_SET_INIT 5'h15
`define QMM_CH_SET_BSIZE 5'h16
`define QMM_CH_GET_WARN 5'h17
`define QMM_CNT_W 16
`define QMM_GAP_W 8
`endif

/* logic/qmm_pkg.sv */
package qmm_pkg;
  typedef enum logic {QMM_READ = 1'b0, QMM_WRITE = 1'b1} qmm_req_t;
  typedef enum logic [2:0] {QMM_IDLE, QMM_INIT, QMM_DRIVE, QMM_RDATA, QMM_GAP} qmm_state_t;
endpackage

/* logic/qmm_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qmm_params.svh"
module qmm_engine #(
  parameter int location_width_param = 32,
  parameter int lanes_per_word       = 4,
  parameter int burst_length_width   = 3,
  parameter int CMD_DEPTH            = 4,
  parameter int RSP_DEPTH            = 4
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic [`QMM_CH_W-1:0]            call_chan,
  input  wire logic [31:0]                     call_data,
  input  wire logic                            call_wr,
  input  wire logic                            call_rd,
  output var  logic [31:0]                     ret_data_r,
  output var  logic                            ret_valid_r,
  output var  logic                            m_read_r,
  output var  logic                            m_write_r,
  output var  logic [location_width_param-1:0] m_addr_r,
  output var  logic [lanes_per_word-1:0]       m_be_r,
  output var  logic [8*lanes_per_word-1:0]     m_wdata_r,
  output var  logic [burst_length_width-1:0]   m_bcnt_r,
  input  wire logic                            m_wait,
  input  wire logic [8*lanes_per_word-1:0]     m_rdata,
  input  wire logic                            m_rvalid,
  output var  logic                            cmd_issued_r,
  output var  logic                            rsp_done_r,
  output var  logic                            all_done_r,
  output var  logic                            warn_range_r,
  output var  logic                            warn_size_r
);
  import qmm_pkg::*;
  localparam int word_width_param = 8 * lanes_per_word;
  localparam int BEATS = 1 << (burst_length_width - 1);
  localparam int BI_W  = $clog2(BEATS);
  localparam int CP_W  = $clog2(CMD_DEPTH);
  localparam int RP_W  = $clog2(RSP_DEPTH);
  localparam int AW    = location_width_param;
  localparam int DW    = word_width_param;
  localparam int LW    = lanes_per_word;
  localparam int BW    = burst_length_width;
  localparam int CW    = `QMM_CNT_W;
  localparam int GW    = `QMM_GAP_W;
  // ---------------------------------------------------------------
  // Call decode
  // ---------------------------------------------------------------
  // The call port is serviced every cycle, whatever the bus is doing.
  wire logic wr_on = call_wr;
  wire logic w_init  = wr_on && call_chan == `QMM_CH_INIT;
  wire logic w_push  = wr_on && call_chan == `QMM_CH_PUSH;
  wire logic w_pop   = wr_on && call_chan == `QMM_CH_POP;
  wire logic w_data  = wr_on && call_chan == `QMM_CH_SET_DATA;
  wire logic w_addr  = wr_on && call_chan == `QMM_CH_SET_ADDR;
  wire logic w_be    = wr_on && call_chan == `QMM_CH_SET_BE;
  wire logic w_bcnt  = wr_on && call_chan == `QMM_CH_SET_BCNT;
  wire logic w_idle  = wr_on && call_chan == `QMM_CH_SET_IDLE;
  wire logic w_req   = wr_on && call_chan == `QMM_CH_SET_REQ;
  wire logic w_index = wr_on && call_chan == `QMM_CH_SET_INDEX;
  wire logic w_init_lat = wr_on && call_chan == `QMM_CH_SET_INIT;
  wire logic w_bsize = wr_on && call_chan == `QMM_CH_SET_BSIZE;
  // ---------------------------------------------------------------
  // Staged command descriptor
  // ---------------------------------------------------------------
  logic            st_req_r;
  logic [AW-1:0]   st_addr_r;
  logic [BW-1:0]   st_bcnt_r;
  logic [BW-1:0]   st_bsize_r;
  logic [GW-1:0]   st_init_r;
  logic [BI_W-1:0] idx_r;
  logic [LW-1:0]   st_be_r   [BEATS];
  logic [DW-1:0]   st_data_r [BEATS];
  logic [GW-1:0]   st_idle_r [BEATS];
  wire logic [BW-1:0] arg_b = call_data[BW-1:0];
  wire logic bcnt_bad = arg_b == '0 || 32'(arg_b) > BEATS;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_req_r     <= 1'b0;
      st_addr_r    <= '0;
      st_bcnt_r    <= BW'(1);
      st_bsize_r   <= BW'(1);
      st_init_r    <= '0;
      idx_r        <= '0;
      warn_range_r <= 1'b0;
      warn_size_r  <= 1'b0;
    end else begin
      if (w_req) st_req_r <= call_data[0];
      if (w_addr) st_addr_r <= call_data[AW-1:0];
      if (w_bcnt) st_bcnt_r <= arg_b;
      if (w_bsize) st_bsize_r <= arg_b;
      if (w_init_lat) st_init_r <= call_data[GW-1:0];
      if (w_index) idx_r <= call_data[BI_W-1:0];
      if (w_bcnt && bcnt_bad) warn_range_r <= 1'b1;
      else if (w_init) warn_range_r <= 1'b0;
      if (w_bsize && arg_b != st_bcnt_r) warn_size_r <= 1'b1;
      else if (w_init) warn_size_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (w_be) st_be_r[idx_r] <= call_data[LW-1:0];
    if (w_data) st_data_r[idx_r] <= call_data[DW-1:0];
    if (w_idle) st_idle_r[idx_r] <= call_data[GW-1:0];
  end

  // ---------------------------------------------------------------
  // Pending command queue
  // ---------------------------------------------------------------
  logic            cq_req   [CMD_DEPTH];
  logic [AW-1:0]   cq_addr  [CMD_DEPTH];
  logic [BW-1:0]   cq_bcnt  [CMD_DEPTH];
  logic [BW-1:0]   cq_bsize [CMD_DEPTH];
  logic [GW-1:0]   cq_init  [CMD_DEPTH];
  logic [LW-1:0]   cq_be    [CMD_DEPTH][BEATS];
  logic [DW-1:0]   cq_data  [CMD_DEPTH][BEATS];
  logic [GW-1:0]   cq_idle  [CMD_DEPTH][BEATS];
  logic [CP_W-1:0] cq_wp_r;
  logic [CP_W-1:0] cq_rp_r;
  logic [CP_W:0]   cq_cnt_r;
  wire logic cq_push = w_push && 32'(cq_cnt_r) < CMD_DEPTH;
  always_ff @(posedge clk) begin
    if (cq_push) begin
      cq_req[cq_wp_r]   <= st_req_r;
      cq_addr[cq_wp_r]  <= st_addr_r;
      cq_bcnt[cq_wp_r]  <= st_bcnt_r;
      cq_bsize[cq_wp_r] <= st_bsize_r;
      cq_init[cq_wp_r]  <= st_init_r;
      for (int i = 0; i < BEATS; i++) begin
        cq_be[cq_wp_r][i]   <= st_be_r[i];
        cq_data[cq_wp_r][i] <= st_data_r[i];
        cq_idle[cq_wp_r][i] <= st_idle_r[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Response queue storage
  // ---------------------------------------------------------------
  logic            rq_req   [RSP_DEPTH];
  logic [AW-1:0]   rq_addr  [RSP_DEPTH];
  logic [BW-1:0]   rq_bsize [RSP_DEPTH];
  logic [LW-1:0]   rq_be    [RSP_DEPTH][BEATS];
  logic [DW-1:0]   rq_data  [RSP_DEPTH][BEATS];
  logic [CW-1:0]   rq_lat   [RSP_DEPTH][BEATS];
  logic [CW-1:0]   rq_wait  [RSP_DEPTH][BEATS];
  logic [RP_W-1:0] rq_wp_r;
  logic [RP_W-1:0] rq_rp_r;
  logic [RP_W-1:0] hold_r;
  logic            held_r;
  logic [RP_W:0]   rq_cnt_r;
  // ---------------------------------------------------------------
  // Bus engine
  // ---------------------------------------------------------------
  qmm_state_t      st_r;
  logic [GW-1:0]   cyc_r;
  logic [CW-1:0]   wt_r;
  logic [CW-1:0]   lt_r;
  logic [BI_W:0]   beat_r;
  logic            issued_r;
  function automatic logic [BI_W:0] beats_of(input logic [BW-1:0] v);
    return (v == '0) ? (BI_W+1)'(1) : (BI_W+1)'(v);
  endfunction

  wire logic [BI_W-1:0] bi = beat_r[BI_W-1:0];
  wire logic cur_wr = cq_req[cq_rp_r];
  // Write beats follow the burst size; read beats follow the burst length.
  wire logic [BI_W:0] n_beats = cur_wr ? beats_of(cq_bsize[cq_rp_r])
                                       : beats_of(cq_bcnt[cq_rp_r]);
  wire logic rq_room = 32'(rq_cnt_r) + 32'(held_r) < RSP_DEPTH;
  wire logic start = st_r == QMM_IDLE && cq_cnt_r != '0 && rq_room && !w_init;
  wire logic accept = (m_read_r || m_write_r) && !m_wait;
  wire logic rbeat = st_r == QMM_RDATA && m_rvalid;
  wire logic last_rb = rbeat && beat_r + 1'b1 == n_beats;
  wire logic more = cur_wr && beat_r < n_beats;
  wire logic finish = st_r == QMM_GAP && cyc_r == '0 && !more;
  wire logic rq_pop = w_pop && rq_cnt_r != '0;

  always_ff @(posedge clk) begin
    if (start) begin
      rq_req[rq_wp_r]   <= cq_req[cq_rp_r];
      rq_addr[rq_wp_r]  <= cq_addr[cq_rp_r];
      rq_bsize[rq_wp_r] <= cur_wr ? cq_bsize[cq_rp_r] : cq_bcnt[cq_rp_r];
    end
    if (st_r == QMM_DRIVE && accept) begin
      rq_wait[rq_wp_r][bi] <= wt_r;
      if (cur_wr) begin
        rq_data[rq_wp_r][bi] <= m_wdata_r;
        rq_be[rq_wp_r][bi]   <= m_be_r;
        rq_lat[rq_wp_r][bi]  <= '0;
      end
    end
    if (rbeat) begin
      rq_data[rq_wp_r][bi] <= m_rdata;
      rq_lat[rq_wp_r][bi]  <= lt_r;
      rq_be[rq_wp_r][bi]   <= cq_be[cq_rp_r][bi];
      if (beat_r != '0) rq_wait[rq_wp_r][bi] <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r         <= QMM_IDLE;
      cyc_r        <= '0;
      wt_r         <= '0;
      lt_r         <= '0;
      beat_r       <= '0;
      issued_r     <= 1'b0;
      m_read_r     <= 1'b0;
      m_write_r    <= 1'b0;
      m_addr_r     <= '0;
      m_be_r       <= '0;
      m_wdata_r    <= '0;
      m_bcnt_r     <= '0;
      cmd_issued_r <= 1'b0;
      rsp_done_r   <= 1'b0;
      all_done_r   <= 1'b0;
    end else begin
      cmd_issued_r <= 1'b0;
      rsp_done_r   <= 1'b0;
      all_done_r   <= 1'b0;
      if (w_init) begin
        st_r      <= QMM_IDLE;
        issued_r  <= 1'b0;
        m_read_r  <= 1'b0;
        m_write_r <= 1'b0;
      end else begin
        unique case (st_r)
          QMM_IDLE: begin
            if (start) begin
              cyc_r  <= cq_init[cq_rp_r];
              beat_r <= '0;
              st_r   <= QMM_INIT;
            end
          end
          QMM_INIT: begin
            if (cyc_r == '0) begin
              m_read_r  <= !cur_wr;
              m_write_r <= cur_wr;
              m_addr_r  <= cq_addr[cq_rp_r];
              m_bcnt_r  <= cq_bcnt[cq_rp_r];
              m_be_r    <= cq_be[cq_rp_r][0];
              m_wdata_r <= cq_data[cq_rp_r][0];
              wt_r      <= '0;
              st_r      <= QMM_DRIVE;
            end else begin
              cyc_r <= cyc_r - 1'b1;
            end
          end
          QMM_DRIVE: begin
            if (!accept) begin
              wt_r <= wt_r + 1'b1;
            end else begin
              m_read_r  <= 1'b0;
              m_write_r <= 1'b0;
              wt_r      <= '0;
              if (beat_r == '0) begin
                cmd_issued_r <= 1'b1;
                issued_r     <= 1'b1;
              end
              if (cur_wr) begin
                cyc_r  <= cq_idle[cq_rp_r][bi];
                beat_r <= beat_r + 1'b1;
                st_r   <= QMM_GAP;
              end else begin
                lt_r <= CW'(1);
                st_r <= QMM_RDATA;
              end
            end
          end
          QMM_RDATA: begin
            if (rbeat) begin
              lt_r   <= CW'(1);
              beat_r <= beat_r + 1'b1;
              if (last_rb) begin
                cyc_r <= cq_idle[cq_rp_r][0];
                st_r  <= QMM_GAP;
              end
            end else begin
              lt_r <= lt_r + 1'b1;
            end
          end
          QMM_GAP: begin
            if (cyc_r != '0) begin
              cyc_r <= cyc_r - 1'b1;
            end else if (more) begin
              // Each write burst word is a transfer of its own.
              m_write_r <= 1'b1;
              m_be_r    <= cq_be[cq_rp_r][bi];
              m_wdata_r <= cq_data[cq_rp_r][bi];
              st_r      <= QMM_DRIVE;
            end else begin
              issued_r   <= 1'b0;
              rsp_done_r <= !cur_wr;
              all_done_r <= cq_cnt_r == (CP_W+1)'(1) && !cq_push;
              st_r       <= QMM_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Queue pointers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cq_wp_r  <= '0;
      cq_rp_r  <= '0;
      cq_cnt_r <= '0;
      rq_wp_r  <= '0;
      rq_rp_r  <= '0;
      rq_cnt_r <= '0;
      hold_r   <= '0;
      held_r   <= 1'b0;
    end else if (w_init) begin
      cq_wp_r  <= '0;
      cq_rp_r  <= '0;
      cq_cnt_r <= '0;
      rq_wp_r  <= '0;
      rq_rp_r  <= '0;
      rq_cnt_r <= '0;
      held_r   <= 1'b0;
    end else begin
      if (cq_push) cq_wp_r <= CP_W'(cq_wp_r + 1'b1);
      if (finish) cq_rp_r <= CP_W'(cq_rp_r + 1'b1);
      cq_cnt_r <= cq_cnt_r + (CP_W+1)'(cq_push) - (CP_W+1)'(finish);
      if (finish) rq_wp_r <= RP_W'(rq_wp_r + 1'b1);
      if (rq_pop) begin
        hold_r  <= rq_rp_r;
        held_r  <= 1'b1;
        rq_rp_r <= RP_W'(rq_rp_r + 1'b1);
      end
      rq_cnt_r <= rq_cnt_r + (RP_W+1)'(finish) - (RP_W+1)'(rq_pop);
    end
  end

  // ---------------------------------------------------------------
  // Return port
  // ---------------------------------------------------------------
  wire logic [CP_W:0] pend = cq_cnt_r - (CP_W+1)'(issued_r);
  wire logic all_idle = cq_cnt_r == '0 && st_r == QMM_IDLE;
  wire logic [31:0] ret_nxt =
      (call_chan == `QMM_CH_ALL_DONE)  ? 32'(all_idle) :
      (call_chan == `QMM_CH_ISSUED_SZ) ? 32'(issued_r) :
      (call_chan == `QMM_CH_PEND_SZ)   ? 32'(pend) :
      (call_chan == `QMM_CH_RSP_SZ)    ? 32'(rq_cnt_r) :
      (call_chan == `QMM_CH_GET_REQ)   ? 32'(rq_req[hold_r]) :
      (call_chan == `QMM_CH_GET_DATA)  ? 32'(rq_data[hold_r][idx_r]) :
      (call_chan == `QMM_CH_GET_ADDR)  ? 32'(rq_addr[hold_r]) :
      (call_chan == `QMM_CH_GET_BE)    ? 32'(rq_be[hold_r][idx_r]) :
      (call_chan == `QMM_CH_GET_BSIZE) ? 32'(rq_bsize[hold_r]) :
      (call_chan == `QMM_CH_GET_LAT)   ? 32'(rq_lat[hold_r][idx_r]) :
      (call_chan == `QMM_CH_GET_WAIT)  ? 32'(rq_wait[hold_r][idx_r]) :
      (call_chan == `QMM_CH_GET_WARN)  ? {30'h0, warn_size_r, warn_range_r} : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ret_data_r  <= '0;
      ret_valid_r <= 1'b0;
    end else begin
      ret_data_r  <= call_rd ? ret_nxt : '0;
      ret_valid_r <= call_rd;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_read_hold: assert property ((m_read_r && m_wait && !w_init) |=> m_read_r && $stable(m_addr_r))
    else $error("read dropped under wait");
  a_write_hold: assert property ((m_write_r && m_wait && !w_init) |=> m_write_r && $stable(m_wdata_r))
    else $error("write changed under wait");
  a_issue_event: assert property ((st_r == QMM_DRIVE && accept && beat_r == '0 && !w_init) |=> cmd_issued_r)
    else $error("issue event missing");
  a_req_code: assert property ($rose(m_write_r) |-> cur_wr == QMM_WRITE)
    else $error("write driven for read");
  a_cmd_push: assert property ((cq_push && !finish && !w_init) |=> cq_cnt_r == $past(cq_cnt_r) + 1'b1)
    else $error("push lost");
  a_rsp_pop: assert property ((rq_pop && !finish && !w_init) |=> rq_cnt_r + 1'b1 == $past(rq_cnt_r))
    else $error("pop lost");
  a_ret_timing: assert property (call_rd |=> ret_valid_r ##1 !$past(call_rd) |-> !ret_valid_r)
    else $error("return timing wrong");
  a_rsp_event: assert property (rsp_done_r |-> $past(st_r == QMM_GAP && !cur_wr))
    else $error("response event without read");
  a_init_delay: assert property ((start && cq_init[cq_rp_r] == GW'(2)) |=> ##2 !m_read_r && !m_write_r ##1 (m_read_r || m_write_r))
    else $error("initial latency wrong");

  c_read_burst: cover property (last_rb && beat_r != '0);
  c_write_wait: cover property (m_write_r && m_wait ##1 accept);
  c_all_done: cover property (all_done_r);
endmodule // qmm_engine
`default_nettype wire

/* verification/qmm_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Slave model: stalls each transfer for wait_cfg cycles, then returns read beats late.
// ----------------------------------------------------------------
module qmm_slave_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        m_read_r,
  input  wire logic        m_write_r,
  input  wire logic [31:0] m_addr_r,
  input  wire logic [2:0]  m_bcnt_r,
  input  wire logic [7:0]  wait_cfg,
  input  wire logic [7:0]  lat_cfg,
  output logic             m_wait,
  output logic [31:0]      m_rdata,
  output logic             m_rvalid
);
  logic [7:0]  wcnt_r;
  logic [7:0]  lcnt_r;
  logic [3:0]  left_r;
  logic [3:0]  beat_r;
  logic [31:0] base_r;
  logic [31:0] tick_r;
  wire         req = m_read_r | m_write_r;
  assign m_wait   = req && (wcnt_r != wait_cfg);
  assign m_rvalid = (left_r != 4'h0) && (lcnt_r == lat_cfg);
  // Outside a beat the data lines carry a changing pattern, never the last word.
  assign m_rdata  = m_rvalid ? base_r + {28'h0, beat_r} * 32'h01010101 : ~tick_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_r <= 8'h00;
      lcnt_r <= 8'h00;
      left_r <= 4'h0;
      beat_r <= 4'h0;
      base_r <= 32'h0;
      tick_r <= 32'h0;
    end else begin
      tick_r <= tick_r + 32'h1;
      wcnt_r <= (req && m_wait) ? wcnt_r + 8'h01 : 8'h00;
      if (m_read_r && !m_wait) begin
        left_r <= (m_bcnt_r == 3'h0) ? 4'h1 : {1'b0, m_bcnt_r};
        beat_r <= 4'h0;
        base_r <= m_addr_r;
        lcnt_r <= 8'h01;
      end else if (left_r != 4'h0) begin
        lcnt_r <= m_rvalid ? 8'h01 : lcnt_r + 8'h01;
        left_r <= m_rvalid ? left_r - 4'h1 : left_r;
        beat_r <= m_rvalid ? beat_r + 4'h1 : beat_r;
      end
    end
  end
endmodule // qmm_slave_model
`default_nettype wire

/* verification/qmm_engine_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qmm_params.svh"
// ----------------------------------------------------------------
// Bench: random transfers through the call port, checked on read-out.
// ----------------------------------------------------------------
module qmm_engine_test;
  import qmm_pkg::*;
  logic clk = 0, rst_n = 0, call_wr = 0, call_rd = 0;
  logic [4:0] call_chan = 0;
  logic [31:0] call_data = 0, ret_data_r, m_addr_r, m_wdata_r, m_rdata, addr, a0, bus_a;
  logic ret_valid_r, m_read_r, m_write_r, m_wait, m_rvalid, cmd_issued_r, rsp_done_r;
  logic all_done_r, warn_range_r, warn_size_r, w;
  logic [3:0] m_be_r;
  logic [2:0] m_bcnt_r, n, bus_n;
  logic [7:0] wait_cfg = 0, lat_cfg = 1;
  logic [31:0] dat [8], wq [$];
  logic [3:0] bee [8], beq [$];
  int seed, n_fail, comparisons, n_iss, n_rsp, n_all, nt, nw, k;
  always #2 clk = ~clk;
  qmm_engine uut (.clk(clk), .rst_n(rst_n), .call_chan(call_chan), .call_data(call_data), .call_wr(call_wr),
    .call_rd(call_rd), .ret_data_r(ret_data_r), .ret_valid_r(ret_valid_r), .m_read_r(m_read_r),
    .m_write_r(m_write_r), .m_addr_r(m_addr_r), .m_be_r(m_be_r), .m_wdata_r(m_wdata_r), .m_bcnt_r(m_bcnt_r),
    .m_wait(m_wait), .m_rdata(m_rdata), .m_rvalid(m_rvalid), .cmd_issued_r(cmd_issued_r),
    .rsp_done_r(rsp_done_r), .all_done_r(all_done_r), .warn_range_r(warn_range_r), .warn_size_r(warn_size_r));
  qmm_slave_model slave (.clk(clk), .rst_n(rst_n), .m_read_r(m_read_r), .m_write_r(m_write_r),
    .m_addr_r(m_addr_r), .m_bcnt_r(m_bcnt_r), .wait_cfg(wait_cfg), .lat_cfg(lat_cfg), .m_wait(m_wait),
    .m_rdata(m_rdata), .m_rvalid(m_rvalid));
  always @(posedge clk) begin
    if ((m_read_r || m_write_r) && !m_wait) beq.push_back(m_be_r);
    if (m_write_r && !m_wait) wq.push_back(m_wdata_r);
    if ((m_read_r || m_write_r) && !m_wait) bus_a = m_addr_r;
    if ((m_read_r || m_write_r) && !m_wait) bus_n = m_bcnt_r;
    n_iss += cmd_issued_r;
    n_rsp += rsp_done_r;
    n_all += all_done_r;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cw(input logic [4:0] ch, input logic [31:0] d);
    @(posedge clk);
    call_chan <= ch;
    call_data <= d;
    call_wr <= 1'b1;
    call_rd <= 1'b0;
  endtask
  task automatic qr(input logic [4:0] ch, output logic [31:0] v);
    @(posedge clk);
    call_chan <= ch;
    call_rd <= 1'b1;
    call_wr <= 1'b0;
    @(posedge clk);
    call_rd <= 1'b0;
    #1;
    chk("ret_valid", {31'h0, ret_valid_r}, 32'h1);
    v = ret_data_r;
  endtask
  task automatic ck(input logic [4:0] ch, input logic [31:0] exp, input string nm);
    logic [31:0] v;
    qr(ch, v);
    chk(nm, v, exp);
  endtask
  task automatic await(input logic [31:0] cnt);
    logic [31:0] v;
    v = 0;
    for (int i = 0; i < 300 && v !== cnt; i++) qr(`QMM_CH_RSP_SZ, v);
    chk("rsp_count", v, cnt);
  endtask
  task automatic push_tx(input logic wr, input logic [2:0] len);
    addr = $random(seed);
    wq.delete();
    beq.delete();
    cw(`QMM_CH_SET_REQ, {31'h0, wr});
    wait_cfg <= 8'($random(seed) & 3);
    lat_cfg <= 8'(1 + ($random(seed) & 1));
    cw(`QMM_CH_SET_ADDR, addr);
    cw(`QMM_CH_SET_BCNT, {29'h0, len});
    cw(`QMM_CH_SET_BSIZE, {29'h0, len});
    cw(`QMM_CH_SET_INIT, 32'($random(seed) & 3));
    for (int i = 0; i < len; i++) begin
      dat[i] = $random(seed);
      bee[i] = 4'($random(seed));
      cw(`QMM_CH_SET_INDEX, i);
      cw(`QMM_CH_SET_DATA, dat[i]);
      cw(`QMM_CH_SET_BE, {28'h0, bee[i]});
      cw(`QMM_CH_SET_IDLE, 32'($random(seed) & 3));
    end
    cw(`QMM_CH_PUSH, 32'h0);
  endtask
  task automatic check_tx(input logic wr, input logic [2:0] len);
    cw(`QMM_CH_POP, 32'h0);
    ck(`QMM_CH_GET_REQ, {31'h0, wr}, "req");
    ck(`QMM_CH_GET_ADDR, addr, "addr");
    ck(`QMM_CH_GET_BSIZE, {29'h0, len}, "bsize");
    chk("bus_addr", bus_a, addr);
    chk("bus_bcnt", {29'h0, bus_n}, {29'h0, len});
    for (int i = 0; i < len; i++) begin
      cw(`QMM_CH_SET_INDEX, i);
      ck(`QMM_CH_GET_BE, {28'h0, bee[i]}, "be");
      ck(`QMM_CH_GET_DATA, wr ? dat[i] : addr + i * 32'h01010101, "data");
      ck(`QMM_CH_GET_LAT, wr ? 32'h0 : {24'h0, lat_cfg}, "latency");
      ck(`QMM_CH_GET_WAIT, (wr || i == 0) ? {24'h0, wait_cfg} : 32'h0, "wait");
      if (wr) chk("bus_wdata", wq.pop_front(), dat[i]);
      if (wr || i == 0) chk("bus_be", {28'h0, beq.pop_front()}, {28'h0, bee[i]});
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    test_done;
  end
  initial begin
    seed = 27307;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("bus_idle", {30'h0, m_read_r, m_write_r}, 32'h0);
    for (k = 0; k < 8; k++) begin
      w = 1'($random(seed));
      n = 3'(1 + ($random(seed) & 3));
      push_tx(w, n);
      await(1);
      check_tx(w, n);
      nt++;
      nw += w;
      $display("test transfer %0d done", k);
    end
    push_tx(1'b0, 3'h1);
    a0 = addr;
    push_tx(1'b1, 3'h2);
    await(2);
    cw(`QMM_CH_POP, 32'h0);
    ck(`QMM_CH_GET_ADDR, a0, "first_addr");
    ck(`QMM_CH_RSP_SZ, 32'h1, "rsp_after_pop");
    cw(`QMM_CH_POP, 32'h0);
    ck(`QMM_CH_GET_ADDR, addr, "second_addr");
    ck(`QMM_CH_PEND_SZ, 32'h0, "pending");
    ck(`QMM_CH_ISSUED_SZ, 32'h0, "issued");
    ck(`QMM_CH_ALL_DONE, 32'h1, "all_done");
    chk("issue_events", n_iss, nt + 2);
    chk("rsp_events", n_rsp, nt - nw + 1);
    chk("done_events", {31'h0, n_all != 0}, 32'h1);
    $display("test ordering done");
    cw(`QMM_CH_SET_BCNT, 32'h0);
    ck(`QMM_CH_GET_WARN, 32'h1, "warn_range");
    chk("warn_range_pin", {31'h0, warn_range_r}, 32'h1);
    cw(`QMM_CH_SET_BCNT, 32'h2);
    cw(`QMM_CH_SET_BSIZE, 32'h3);
    ck(`QMM_CH_GET_WARN, 32'h3, "warn_size");
    chk("warn_size_pin", {31'h0, warn_size_r}, 32'h1);
    cw(`QMM_CH_INIT, 32'h0);
    ck(`QMM_CH_GET_WARN, 32'h0, "warn_cleared");
    chk("warn_pins_clear", {30'h0, warn_size_r, warn_range_r}, 32'h0);
    ck(5'h1F, 32'h0, "unknown_chan");
    $display("test warnings done");
    test_done;
  end
endmodule // qmm_engine_test
`default_nettype wire
